// ### shared/sad_pkg.sv
// Purpose: Shared constants and types for the system address decoder.
// Assumes: One processor bus master, one clock, synchronous reset.
// Notes:   Offsets are byte offsets inside the system control bank.
package sad_pkg;

	// Region windows: base and offset of the last byte.
	localparam logic [31:0] APP_FLASH_BASE    = 32'h0000_0000;
	localparam logic [31:0] APP_FLASH_LAST    = 32'h0000_75ff;
	localparam logic [31:0] LOADER_BASE       = 32'h0010_0000;
	localparam logic [31:0] LOADER_LAST       = 32'h0000_07ff;
	localparam logic [31:0] SECURE_MEM_ZERO   = 32'h0020_0000;
	localparam logic [31:0] SECURE_MEM_ONE    = 32'h0024_0000;
	localparam logic [31:0] SECURE_MEM_TWO    = 32'h0028_0000;
	localparam logic [31:0] SECURE_LAST       = 32'h0000_01ff;
	localparam logic [31:0] SRAM_BASE         = 32'h2000_0000;
	localparam logic [31:0] SRAM_WIN_LAST     = 32'h1fff_ffff;
	localparam logic [31:0] SYSCTRL_BASE      = 32'h5000_0000;
	localparam logic [31:0] SYSCTRL_LAST      = 32'h0000_01ff;
	localparam logic [31:0] CLOCK_BASE        = 32'h5000_0200;
	localparam logic [31:0] INTMUX_BASE       = 32'h5000_0300;
	localparam logic [31:0] SMALL_LAST        = 32'h0000_00ff;
	localparam logic [31:0] GPIO_BASE         = 32'h5000_4000;
	localparam logic [31:0] FLASH_CTRL_BASE   = 32'h5000_c000;
	localparam logic [31:0] DIVIDER_BASE      = 32'h5001_4000;
	localparam logic [31:0] WATCHDOG_BASE     = 32'h4000_4000;
	localparam logic [31:0] DUAL_TIMER_BASE   = 32'h4001_0000;
	localparam logic [31:0] ENH_PULSE_BASE    = 32'h4004_0000;
	localparam logic [31:0] SERIAL_IF_A_BASE  = 32'h4007_0000;
	localparam logic [31:0] COMPARATOR_BASE   = 32'h400d_0000;
	localparam logic [31:0] ADC_BASE          = 32'h400e_0000;
	localparam logic [31:0] GAIN_AMP_BASE     = 32'h400f_0000;
	localparam logic [31:0] BASIC_PULSE_BASE  = 32'h4014_0000;
	localparam logic [31:0] SERIAL_IF_B_BASE  = 32'h4017_0000;
	localparam logic [31:0] CAPTURE_BASE      = 32'h401b_0000;
	localparam logic [31:0] WIN16K_LAST       = 32'h0000_3fff;
	localparam logic [31:0] SYSTICK_BASE      = 32'he000_e010;
	localparam logic [31:0] SYSTICK_LAST      = 32'h0000_00ef;
	localparam logic [31:0] NVIC_BASE         = 32'he000_e100;
	localparam logic [31:0] NVIC_LAST         = 32'h0000_0bff;
	localparam logic [31:0] CORE_CTRL_BASE    = 32'he000_ed00;
	localparam logic [31:0] CORE_CTRL_LAST    = 32'h0000_008f;

	// System control bank offsets.
	localparam logic [8:0] PART_IDENTITY_OFF  = 9'h000;
	localparam logic [8:0] RESET_SOURCE_OFF   = 9'h004;
	localparam logic [8:0] PERIPH_RST_A_OFF   = 9'h008;
	localparam logic [8:0] PERIPH_RST_B_OFF   = 9'h00c;
	localparam logic [8:0] BUS_WAIT_OFF       = 9'h010;
	localparam logic [8:0] BROWNOUT_OFF       = 9'h018;
	localparam logic [8:0] VSOURCE_OFF        = 9'h01c;
	localparam logic [8:0] POR_CTRL_OFF       = 9'h024;
	localparam logic [8:0] PIN_FUNC_A_OFF     = 9'h030;
	localparam logic [8:0] PIN_FUNC_B_OFF     = 9'h034;
	localparam logic [8:0] PIN_FUNC_C_OFF     = 9'h038;
	localparam logic [8:0] PIN_FUNC_D_OFF     = 9'h03c;
	localparam logic [8:0] TRIM_CTRL_OFF      = 9'h080;
	localparam logic [8:0] TRIM_IRQ_EN_OFF    = 9'h084;
	localparam logic [8:0] TRIM_IRQ_STS_OFF   = 9'h088;
	localparam logic [8:0] WRITE_PROTECT_OFF  = 9'h100;
	localparam logic [8:0] TEMP_OFFSET_OFF    = 9'h114;

	// Reset values.
	localparam logic [31:0] BUS_WAIT_RST      = 32'h0000_0001;
	localparam logic [31:0] BROWNOUT_RST      = 32'h0000_8000;
	localparam logic [31:0] PIN_FUNC_D_RST    = 32'h0000_0111;
	localparam logic [31:0] TRIM_CTRL_RST     = 32'h0000_0030;

	// Protected bits, and the implemented reset source flags.
	localparam logic [31:0] PERIPH_RST_A_PROT = 32'h0000_0003;
	localparam logic [31:0] BROWNOUT_PROT     = 32'h0000_805f;
	localparam logic [31:0] POR_CTRL_PROT     = 32'h0000_ffff;
	localparam logic [7:0]  RESET_SOURCE_MASK = 8'hbf;

	// Unlock key bytes.
	localparam logic [7:0] UNLOCK_KEY_ONE     = 8'h59;
	localparam logic [7:0] UNLOCK_KEY_TWO     = 8'h16;
	localparam logic [7:0] UNLOCK_KEY_THREE   = 8'h88;

	// Access sizes.
	localparam logic [1:0] SIZE_BYTE          = 2'h0;
	localparam logic [1:0] SIZE_HALF          = 2'h1;

	typedef enum logic [4:0] {
		REG_NONE, REG_APP_FLASH, REG_LOADER, REG_SECURE0, REG_SECURE1,
		REG_SECURE2, REG_SRAM, REG_SYSCTRL, REG_CLOCK, REG_INTMUX,
		REG_GPIO, REG_FLASH_CTRL, REG_DIVIDER, REG_WATCHDOG,
		REG_DUAL_TIMER, REG_ENH_PULSE, REG_SERIAL_A, REG_COMPARATOR,
		REG_ADC, REG_GAIN_AMP, REG_BASIC_PULSE, REG_SERIAL_B,
		REG_CAPTURE, REG_SYSTICK, REG_NVIC, REG_CORE_CTRL
	} sad_region_type;

	typedef struct packed {
		logic        write;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} sad_req_type;

	typedef struct packed {
		logic        valid;
		logic        err;
		logic [31:0] rdata;
	} sad_resp_type;

	typedef struct packed {
		logic           strobe;
		sad_region_type region;
		logic           write;
		logic [3:0]     be;
		logic [31:0]    addr;
		logic [31:0]    wdata;
	} sad_tgt_type;

	typedef struct packed {
		logic [31:0] periph_rst_a;
		logic [31:0] periph_rst_b;
		logic [31:0] bus_wait;
		logic [31:0] brownout;
		logic [31:0] vsource;
		logic [31:0] por_ctrl;
		logic [31:0] pin_func_a;
		logic [31:0] pin_func_b;
		logic [31:0] pin_func_c;
		logic [31:0] pin_func_d;
		logic [31:0] trim_ctrl;
		logic [31:0] trim_irq_en;
	} sad_sysctl_type;

endpackage

// ### logic/sad_top.sv
// Purpose: System address decoder with on-chip SRAM and the system
//          control register bank.
// Assumes: One access outstanding at a time; the master waits for
//          resp_o.valid before it issues the next request.
// Notes:   Data is little-endian, byte lanes placed by address.
// Summary of operation
// - Decode the full 32-bit address of every access over a 4 GB space.
// - Little-endian only; lowest address holds the least significant byte.
// - Addresses 0x0000_0000 to 0x0000_75FF select application flash.
// - Addresses 0x0010_0000 to 0x0010_07FF select the loader flash.
// - Three 512-byte secure memories at their three bases.
// - Addresses 0x2000_0000 to 0x2000_0FFF select the 4 KB SRAM.
// - System, clock and interrupt multiplexer banks in high-speed space.
// - Pin, flash controller and divider 16 KB windows in high-speed space.
// - Watchdog and dual timer 16 KB windows in low-speed space.
// - Enhanced pulse modulator and first serial interface windows.
// - Comparator, converter and gain amplifier windows, in that order.
// - Basic pulse modulator, second serial interface, capture windows.
// - System tick, interrupt controller and core control in private space.
// - SRAM byte, halfword and word writes touch only addressed lanes.
// - SRAM answers with a bus error beyond its implemented size.
// - Control bank at 0x5000_0000; read-only ignore writes, others hold.
// - Unlock needs 59h, 16h, 88h back to back; any other write aborts, reads do not.
// - Unlocked reads bit 0 as one; any write there that includes byte lane 0 locks again.
`timescale 1ns/10ps
`default_nettype none
module sad_top
	import sad_pkg::*;
#(
	parameter int          SRAM_BYTES    = 4096,
	// Identity value is arbitrary; the product sets its own.
	parameter logic [31:0] PART_ID       = 32'h0000_1234,
	parameter logic [31:0] TEMP_OFFSET   = 32'h0000_0000
) (
	// Clock and reset.
	input  wire logic                    mclk_i,
	input  wire logic                    srst_i,
	// Processor bus request and answer.
	input  wire logic                    req_valid_i,
	input  wire sad_pkg::sad_req_type    req_i,
	output logic                         busy_o,
	output sad_pkg::sad_resp_type        resp_o,
	// External targets.
	output sad_pkg::sad_tgt_type         tgt_o,
	input  wire logic                    ext_ack_i,
	input  wire logic                    ext_err_i,
	input  wire logic [31:0]             ext_rdata_i,
	// System events and control outputs.
	input  wire logic [7:0]              rst_flag_set_i,
	input  wire logic [31:0]             trim_flag_set_i,
	output sad_pkg::sad_sysctl_type      sysctl_o,
	output logic                         unlocked_o
);
	import sad_pkg::*;

	localparam int WORDS  = SRAM_BYTES / 4;
	localparam int IDX_W  = $clog2(WORDS);

	if (SRAM_BYTES < 8 || (SRAM_BYTES & (SRAM_BYTES - 1)) != 0 ||
			SRAM_BYTES > 32'h2000_0000) begin : g_size_check
		$error("SRAM_BYTES must be a power of two within the window.");
	end

	typedef enum logic [1:0] {
		LK_LOCKED, LK_KEY1, LK_KEY2, LK_OPEN
	} sad_lock_type;

	sad_lock_type   lock_reg;
	sad_lock_type   lock_next;
	logic           unlocked_reg;
	sad_resp_type   resp_reg;
	sad_tgt_type    tgt_reg;
	sad_sysctl_type ctl_reg;
	logic           busy_reg;
	logic [7:0]     rst_sts_reg;
	logic [31:0]    trim_sts_reg;
	logic [31:0]    mem [WORDS];

	sad_region_type region;
	logic           take;
	logic           is_ext;
	logic           sram_over;
	logic [31:0]    sram_off;
	logic [IDX_W-1:0] word_idx;
	logic [3:0]     be;
	logic [31:0]    wmask;
	logic [8:0]     sys_off;
	logic           sys_wr;
	logic [31:0]    sys_rdata;

	function automatic logic hit(input logic [31:0] a,
			input logic [31:0] base, input logic [31:0] last);
		hit = (a >= base) && ((a - base) <= last);
	endfunction

	// Full-width compares, so aliases of a window never decode.
	always_comb begin
		region = REG_NONE;
		if (hit(req_i.addr, APP_FLASH_BASE, APP_FLASH_LAST))
			region = REG_APP_FLASH;
		else if (hit(req_i.addr, LOADER_BASE, LOADER_LAST))
			region = REG_LOADER;
		else if (hit(req_i.addr, SECURE_MEM_ZERO, SECURE_LAST))
			region = REG_SECURE0;
		else if (hit(req_i.addr, SECURE_MEM_ONE, SECURE_LAST))
			region = REG_SECURE1;
		else if (hit(req_i.addr, SECURE_MEM_TWO, SECURE_LAST))
			region = REG_SECURE2;
		else if (hit(req_i.addr, SRAM_BASE, SRAM_WIN_LAST))
			region = REG_SRAM;
		else if (hit(req_i.addr, SYSCTRL_BASE, SYSCTRL_LAST))
			region = REG_SYSCTRL;
		else if (hit(req_i.addr, CLOCK_BASE, SMALL_LAST))
			region = REG_CLOCK;
		else if (hit(req_i.addr, INTMUX_BASE, SMALL_LAST))
			region = REG_INTMUX;
		else if (hit(req_i.addr, GPIO_BASE, WIN16K_LAST))
			region = REG_GPIO;
		else if (hit(req_i.addr, FLASH_CTRL_BASE, WIN16K_LAST))
			region = REG_FLASH_CTRL;
		else if (hit(req_i.addr, DIVIDER_BASE, WIN16K_LAST))
			region = REG_DIVIDER;
		else if (hit(req_i.addr, WATCHDOG_BASE, WIN16K_LAST))
			region = REG_WATCHDOG;
		else if (hit(req_i.addr, DUAL_TIMER_BASE, WIN16K_LAST))
			region = REG_DUAL_TIMER;
		else if (hit(req_i.addr, ENH_PULSE_BASE, WIN16K_LAST))
			region = REG_ENH_PULSE;
		else if (hit(req_i.addr, SERIAL_IF_A_BASE, WIN16K_LAST))
			region = REG_SERIAL_A;
		else if (hit(req_i.addr, COMPARATOR_BASE, WIN16K_LAST))
			region = REG_COMPARATOR;
		else if (hit(req_i.addr, ADC_BASE, WIN16K_LAST))
			region = REG_ADC;
		else if (hit(req_i.addr, GAIN_AMP_BASE, WIN16K_LAST))
			region = REG_GAIN_AMP;
		else if (hit(req_i.addr, BASIC_PULSE_BASE, WIN16K_LAST))
			region = REG_BASIC_PULSE;
		else if (hit(req_i.addr, SERIAL_IF_B_BASE, WIN16K_LAST))
			region = REG_SERIAL_B;
		else if (hit(req_i.addr, CAPTURE_BASE, WIN16K_LAST))
			region = REG_CAPTURE;
		else if (hit(req_i.addr, SYSTICK_BASE, SYSTICK_LAST))
			region = REG_SYSTICK;
		else if (hit(req_i.addr, NVIC_BASE, NVIC_LAST))
			region = REG_NVIC;
		else if (hit(req_i.addr, CORE_CTRL_BASE, CORE_CTRL_LAST))
			region = REG_CORE_CTRL;
	end

	// Little-endian lanes: the lowest address drives byte lane 0.
	always_comb begin
		unique case (req_i.size)
			SIZE_BYTE: be = 4'h1 << req_i.addr[1:0];
			SIZE_HALF: be = req_i.addr[1] ? 4'hc : 4'h3;
			default:   be = 4'hf;
		endcase
		for (int i = 0; i < 4; i++) begin
			wmask[8*i +: 8] = {8{be[i]}};
		end
	end

	assign take      = req_valid_i && !busy_reg;
	assign is_ext    = !(region inside {REG_NONE, REG_SRAM, REG_SYSCTRL});
	assign sram_off  = req_i.addr - SRAM_BASE;
	assign sram_over = sram_off >= 32'(SRAM_BYTES);
	assign word_idx  = sram_off[IDX_W+1:2];
	assign sys_off   = req_i.addr[8:0];
	assign sys_wr    = take && req_i.write && region == REG_SYSCTRL;

	// Answer for internal targets one edge after the request.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			resp_reg <= '0;
		end else begin
			resp_reg.valid <= 1'b0;
			if (take && !is_ext) begin
				resp_reg.valid <= 1'b1;
				resp_reg.err   <= region == REG_NONE ||
					(region == REG_SRAM && sram_over);
				if (region == REG_SRAM && !sram_over && !req_i.write)
					resp_reg.rdata <= mem[word_idx];
				else if (region == REG_SYSCTRL && !req_i.write)
					resp_reg.rdata <= sys_rdata;
				else
					resp_reg.rdata <= '0;
			end else if (busy_reg && ext_ack_i) begin
				resp_reg.valid <= 1'b1;
				resp_reg.err   <= ext_err_i;
				resp_reg.rdata <= ext_rdata_i;
			end
		end
	end

	// Outside targets get a one-cycle strobe; fields hold until the next.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			tgt_reg  <= '0;
			busy_reg <= 1'b0;
		end else begin
			tgt_reg.strobe <= 1'b0;
			if (take && is_ext) begin
				tgt_reg  <= {1'b1, region, req_i.write, be,
					req_i.addr, req_i.wdata};
				busy_reg <= 1'b1;
			end else if (busy_reg && ext_ack_i) begin
				busy_reg <= 1'b0;
			end
		end
	end

	// No reset on the array, so it maps onto a plain RAM macro.
	always_ff @(posedge mclk_i) begin
		if (take && req_i.write && region == REG_SRAM && !sram_over) begin
			for (int i = 0; i < 4; i++) begin
				if (be[i])
					mem[word_idx][8*i +: 8] <= req_i.wdata[8*i +: 8];
			end
		end
	end

	// Any write other than the next key byte while a key is half entered aborts it.
	always_comb begin
		lock_next = lock_reg;
		if (take && req_i.write) begin
			if (sys_wr && sys_off == WRITE_PROTECT_OFF && be[0]) begin
				unique case (lock_reg)
					LK_LOCKED: lock_next =
						req_i.wdata[7:0] == UNLOCK_KEY_ONE ?
						LK_KEY1 : LK_LOCKED;
					LK_KEY1: lock_next =
						req_i.wdata[7:0] == UNLOCK_KEY_TWO ?
						LK_KEY2 : LK_LOCKED;
					LK_KEY2: lock_next =
						req_i.wdata[7:0] == UNLOCK_KEY_THREE ?
						LK_OPEN : LK_LOCKED;
					LK_OPEN: lock_next = LK_LOCKED;
				endcase
			end else if (lock_reg != LK_OPEN) begin
				lock_next = LK_LOCKED;
			end
		end
	end

	// The open flag has its own flop so the pin is glitch free.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			lock_reg     <= LK_LOCKED;
			unlocked_reg <= 1'b0;
		end else begin
			lock_reg     <= lock_next;
			unlocked_reg <= lock_next == LK_OPEN;
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] data, input logic [31:0] mask);
		merge = (old & ~mask) | (data & mask);
	endfunction

	// Protected bits take a write only while the bank is unlocked.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			ctl_reg            <= '0;
			ctl_reg.bus_wait   <= BUS_WAIT_RST;
			ctl_reg.brownout   <= BROWNOUT_RST;
			ctl_reg.pin_func_d <= PIN_FUNC_D_RST;
			ctl_reg.trim_ctrl  <= TRIM_CTRL_RST;
		end else if (sys_wr) begin
			unique case (sys_off)
				PERIPH_RST_A_OFF: ctl_reg.periph_rst_a <=
					merge(ctl_reg.periph_rst_a, req_i.wdata, wmask &
					(lock_reg == LK_OPEN ? '1 : ~PERIPH_RST_A_PROT));
				PERIPH_RST_B_OFF: ctl_reg.periph_rst_b <=
					merge(ctl_reg.periph_rst_b, req_i.wdata, wmask);
				BUS_WAIT_OFF: ctl_reg.bus_wait <=
					merge(ctl_reg.bus_wait, req_i.wdata, wmask);
				BROWNOUT_OFF: ctl_reg.brownout <=
					merge(ctl_reg.brownout, req_i.wdata, wmask &
					(lock_reg == LK_OPEN ? '1 : ~BROWNOUT_PROT));
				VSOURCE_OFF: ctl_reg.vsource <=
					merge(ctl_reg.vsource, req_i.wdata, wmask);
				POR_CTRL_OFF: ctl_reg.por_ctrl <=
					merge(ctl_reg.por_ctrl, req_i.wdata, wmask &
					(lock_reg == LK_OPEN ? '1 : ~POR_CTRL_PROT));
				PIN_FUNC_A_OFF: ctl_reg.pin_func_a <=
					merge(ctl_reg.pin_func_a, req_i.wdata, wmask);
				PIN_FUNC_B_OFF: ctl_reg.pin_func_b <=
					merge(ctl_reg.pin_func_b, req_i.wdata, wmask);
				PIN_FUNC_C_OFF: ctl_reg.pin_func_c <=
					merge(ctl_reg.pin_func_c, req_i.wdata, wmask);
				PIN_FUNC_D_OFF: ctl_reg.pin_func_d <=
					merge(ctl_reg.pin_func_d, req_i.wdata, wmask);
				TRIM_CTRL_OFF: ctl_reg.trim_ctrl <=
					merge(ctl_reg.trim_ctrl, req_i.wdata, wmask);
				TRIM_IRQ_EN_OFF: ctl_reg.trim_irq_en <=
					merge(ctl_reg.trim_irq_en, req_i.wdata, wmask);
				default: ctl_reg <= ctl_reg;
			endcase
		end
	end

	// Write-one-to-clear flags; a new event in the clearing cycle wins.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			rst_sts_reg  <= '0;
			trim_sts_reg <= '0;
		end else begin
			rst_sts_reg <= ((rst_sts_reg & ~((sys_wr &&
				sys_off == RESET_SOURCE_OFF) ? req_i.wdata[7:0] &
				wmask[7:0] : 8'h00)) | rst_flag_set_i) &
				RESET_SOURCE_MASK;
			trim_sts_reg <= (trim_sts_reg & ~((sys_wr &&
				sys_off == TRIM_IRQ_STS_OFF) ? req_i.wdata & wmask :
				32'h0000_0000)) | trim_flag_set_i;
		end
	end

	always_comb begin
		unique case (sys_off)
			PART_IDENTITY_OFF: sys_rdata = PART_ID;
			RESET_SOURCE_OFF:  sys_rdata = {24'h00_0000, rst_sts_reg};
			PERIPH_RST_A_OFF:  sys_rdata = ctl_reg.periph_rst_a;
			PERIPH_RST_B_OFF:  sys_rdata = ctl_reg.periph_rst_b;
			BUS_WAIT_OFF:      sys_rdata = ctl_reg.bus_wait;
			BROWNOUT_OFF:      sys_rdata = ctl_reg.brownout;
			VSOURCE_OFF:       sys_rdata = ctl_reg.vsource;
			POR_CTRL_OFF:      sys_rdata = ctl_reg.por_ctrl;
			PIN_FUNC_A_OFF:    sys_rdata = ctl_reg.pin_func_a;
			PIN_FUNC_B_OFF:    sys_rdata = ctl_reg.pin_func_b;
			PIN_FUNC_C_OFF:    sys_rdata = ctl_reg.pin_func_c;
			PIN_FUNC_D_OFF:    sys_rdata = ctl_reg.pin_func_d;
			TRIM_CTRL_OFF:     sys_rdata = ctl_reg.trim_ctrl;
			TRIM_IRQ_EN_OFF:   sys_rdata = ctl_reg.trim_irq_en;
			TRIM_IRQ_STS_OFF:  sys_rdata = trim_sts_reg;
			WRITE_PROTECT_OFF: sys_rdata =
				{31'h0000_0000, lock_reg == LK_OPEN};
			TEMP_OFFSET_OFF:   sys_rdata = TEMP_OFFSET;
			default:           sys_rdata = '0;
		endcase
	end

	assign resp_o     = resp_reg;
	assign tgt_o      = tgt_reg;
	assign busy_o     = busy_reg;
	assign sysctl_o   = ctl_reg;
	assign unlocked_o = unlocked_reg;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	answer_one_a: assert property (
		take && !is_ext |=> resp_o.valid && !tgt_o.strobe)
		else $error("Internal access not answered next cycle.");

	flash_route_a: assert property (
		take && req_i.addr <= APP_FLASH_LAST |=>
		tgt_o.strobe && tgt_o.region == REG_APP_FLASH)
		else $error("Application flash access not routed.");

	tick_route_a: assert property (
		take && req_i.addr == SYSTICK_BASE |=>
		tgt_o.strobe && tgt_o.region == REG_SYSTICK)
		else $error("System tick access not routed.");

	sram_over_a: assert property (
		take && region == REG_SRAM && sram_over |=> resp_o.err)
		else $error("Oversize SRAM access gave no error.");

	reserved_err_a: assert property (
		take && region == REG_NONE |=>
		resp_o.valid && resp_o.err && !tgt_o.strobe &&
		$stable(ctl_reg) && $stable(lock_reg))
		else $error("Reserved access was not refused cleanly.");

	lane_keep_a: assert property (
		take && req_i.write && region == REG_SRAM && !sram_over &&
		req_i.size == SIZE_BYTE |=>
		((mem[$past(word_idx)] ^ $past(mem[word_idx])) &
		~$past(wmask)) == 32'h0000_0000)
		else $error("SRAM write disturbed an unaddressed lane.");

	unlock_seq_a: assert property (
		lock_reg == LK_KEY2 && sys_wr && sys_off == WRITE_PROTECT_OFF &&
		be[0] && req_i.wdata[7:0] == UNLOCK_KEY_THREE |=> unlocked_o)
		else $error("Third key did not unlock.");

	abort_seq_a: assert property (
		lock_reg inside {LK_KEY1, LK_KEY2} && take && req_i.write &&
		!(sys_wr && sys_off == WRITE_PROTECT_OFF) |=>
		lock_reg == LK_LOCKED)
		else $error("Foreign write did not abort the unlock.");

	relock_a: assert property (
		unlocked_o && sys_wr && sys_off == WRITE_PROTECT_OFF && be[0] |=>
		!unlocked_o ##1 !unlocked_o)
		else $error("Write to protect control did not relock.");

	protect_hold_a: assert property (
		!unlocked_o && sys_wr && sys_off == POR_CTRL_OFF |=>
		(sysctl_o.por_ctrl & POR_CTRL_PROT) ==
		($past(sysctl_o.por_ctrl) & POR_CTRL_PROT))
		else $error("Protected bits changed while locked.");

endmodule
`default_nettype wire

// ### testbench/sad_ext_target.sv
// Purpose: Far-side model of the external targets behind the decoder.
// Assumes: One strobe at a time; slow_i adds three wait cycles.
// Notes:   Read data is a pattern of the address, inverted when idle.
`timescale 1ns/10ps
`default_nettype none
module sad_ext_target
	import sad_pkg::*;
(
	// Clock and control.
	input  wire logic                 mclk_i,
	input  wire logic                 srst_i,
	input  wire logic                 slow_i,
	// Target side of the decoder.
	input  wire sad_pkg::sad_tgt_type tgt_i,
	output logic                      ext_ack_o,
	output logic                      ext_err_o,
	output logic [31:0]               ext_rdata_o
);
	logic       pend_reg;
	logic [1:0] wait_reg;

	always_ff @(posedge mclk_i) begin
		if (srst_i || ext_ack_o) begin
			pend_reg <= 1'b0;
		end else if (tgt_i.strobe) begin
			pend_reg <= 1'b1;
			wait_reg <= slow_i ? 2'h3 : 2'h0;
		end else if (wait_reg != 2'h0) begin
			wait_reg <= wait_reg - 2'h1;
		end
	end

	assign ext_ack_o = pend_reg && (wait_reg == 2'h0);
	assign ext_err_o = 1'b0;
	// Idle data is inverted so a stale sample never passes as valid.
	assign ext_rdata_o = ext_ack_o ? (tgt_i.addr ^ 32'h5a5a_0000) :
		~(tgt_i.addr ^ 32'h5a5a_0000);
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Purpose: Self-checking bench for the system address decoder.
// Assumes: Requests driven at the falling edge, one outstanding.
// Notes:   External reads are checked against the target model pattern.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import sad_pkg::*;
	logic           mclk_i = 1'b0;
	logic           srst_i = 1'b1;
	logic           req_valid_i = 1'b0;
	sad_req_type    req_i = '0;
	logic           busy_o, ack, err, unlocked_o, slow = 1'b0;
	sad_resp_type   resp_o;
	sad_tgt_type    tgt;
	sad_sysctl_type sysctl;
	logic [31:0]    ext_rdata, rd;
	logic [7:0]     rst_flag = 8'h00;
	logic           er;
	int             failures = 0;
	int             cmp_count = 0;
	int             cycles = 0;
	logic [31:0] ext_a [23] = '{32'h0000_75ff, 32'h0010_07ff, 32'h0020_01ff,
		32'h0024_0000, 32'h0028_01ff, 32'h5000_0200, 32'h5000_03ff,
		32'h5000_4000, 32'h5000_ffff, 32'h5001_4000, 32'h4000_7fff,
		32'h4001_0000, 32'h4004_0000, 32'h4007_3fff, 32'h400d_0000,
		32'h400e_0000, 32'h400f_0000, 32'h4014_0000, 32'h4017_0000,
		32'h401b_3fff, 32'he000_e010, 32'he000_e100, 32'he000_ed8f};
	logic [31:0] bad_a [5] = '{32'h0000_7600, 32'h0010_0800,
		32'h2000_1000, 32'h5000_0400, 32'he000_ed90};

	always #2 mclk_i = ~mclk_i;

	// PART_ID is an arbitrary neutral value.
	sad_top #(.PART_ID(32'h0000_abcd)) dut (.mclk_i(mclk_i),
		.srst_i(srst_i), .req_valid_i(req_valid_i), .req_i(req_i),
		.busy_o(busy_o), .resp_o(resp_o), .tgt_o(tgt), .ext_ack_i(ack),
		.ext_err_i(err), .ext_rdata_i(ext_rdata),
		.rst_flag_set_i(rst_flag), .trim_flag_set_i(32'h0),
		.sysctl_o(sysctl), .unlocked_o(unlocked_o));

	sad_ext_target far (.mclk_i(mclk_i), .srst_i(srst_i), .slow_i(slow),
		.tgt_i(tgt), .ext_ack_o(ack), .ext_err_o(err),
		.ext_rdata_o(ext_rdata));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic acc(input logic w, input logic [1:0] sz,
		input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(negedge mclk_i);
		req_valid_i = 1'b1;
		req_i = '{w, sz, a, d};
		@(negedge mclk_i);
		req_valid_i = 1'b0;
		while (resp_o.valid !== 1'b1 && n < 20) begin
			@(negedge mclk_i);
			n++;
		end
		rd = resp_o.rdata;
		er = resp_o.err;
	endtask

	task automatic rg(input logic [8:0] off, input logic [31:0] exp);
		acc(1'b0, 2'h2, SYSCTRL_BASE + {23'h0, off}, 32'h0);
		chk(rd, exp);
	endtask

	task automatic wr(input logic [8:0] off, input logic [31:0] d);
		acc(1'b1, 2'h2, SYSCTRL_BASE + {23'h0, off}, d);
	endtask

	task automatic finish_test;
		$display("Comparisons %0d, failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			finish_test();
		end
	end

	initial begin
		repeat (5) @(negedge mclk_i);
		srst_i = 1'b0;
		rg(BUS_WAIT_OFF, BUS_WAIT_RST);
		rg(PIN_FUNC_D_OFF, PIN_FUNC_D_RST);
		rg(TRIM_CTRL_OFF, TRIM_CTRL_RST);
		wr(PART_IDENTITY_OFF, 32'hffff_ffff);
		rg(PART_IDENTITY_OFF, 32'h0000_abcd);
		wr(VSOURCE_OFF, 32'hdead_beef);
		rg(VSOURCE_OFF, 32'hdead_beef);
		chk(sysctl.vsource, 32'hdead_beef);
		rg(9'h020, 32'h0);
		rst_flag = 8'hff;
		@(negedge mclk_i);
		rst_flag = 8'h00;
		wr(RESET_SOURCE_OFF, 32'h0000_000f);
		rg(RESET_SOURCE_OFF, {24'h0, RESET_SOURCE_MASK & 8'hf0});
		for (int i = 0; i < 23; i++) begin
			slow = i[0];
			acc(1'b0, 2'h2, ext_a[i], 32'h0);
			chk(rd, ext_a[i] ^ 32'h5a5a_0000);
			chk(32'(tgt.region), 32'(i < 5 ? i + 1 : i + 3));
			chk(tgt.addr, ext_a[i]);
			chk({31'h0, busy_o}, 32'h0);
		end
		acc(1'b1, SIZE_BYTE, 32'h4000_4001, 32'h0000_ab00);
		chk(32'({tgt.write, tgt.be}), 32'h12);
		chk(tgt.wdata, 32'h0000_ab00);
		acc(1'b1, 2'h2, 32'h2000_0ffc, 32'h4433_2211);
		acc(1'b1, SIZE_BYTE, 32'h2000_0ffd, 32'h0000_aa00);
		acc(1'b1, SIZE_HALF, 32'h2000_0ffe, 32'hbbbb_0000);
		acc(1'b0, 2'h2, 32'h2000_0ffc, 32'h0);
		chk(rd, 32'hbbbb_aa11);
		acc(1'b1, 2'h2, 32'h2000_0000, 32'h1234_5678);
		for (int i = 0; i < 5; i++) begin
			acc(1'b1, 2'h2, bad_a[i], 32'h0);
			chk({31'h0, er}, 32'h1);
		end
		acc(1'b0, 2'h2, 32'h2000_0ffc, 32'h0);
		chk(rd, 32'hbbbb_aa11);
		acc(1'b0, 2'h2, 32'h2000_0000, 32'h0);
		chk(rd, 32'h1234_5678);
		wr(BROWNOUT_OFF, 32'hffff_ffff);
		rg(BROWNOUT_OFF, 32'hffff_ffa0);
		wr(POR_CTRL_OFF, 32'hffff_ffff);
		rg(POR_CTRL_OFF, 32'hffff_0000);
		wr(WRITE_PROTECT_OFF, 32'h59);
		wr(VSOURCE_OFF, 32'h0);
		wr(WRITE_PROTECT_OFF, 32'h16);
		wr(WRITE_PROTECT_OFF, 32'h88);
		rg(WRITE_PROTECT_OFF, 32'h0);
		wr(WRITE_PROTECT_OFF, 32'h59);
		wr(WRITE_PROTECT_OFF, 32'h16);
		wr(WRITE_PROTECT_OFF, 32'h88);
		rg(WRITE_PROTECT_OFF, 32'h1);
		wr(BROWNOUT_OFF, 32'h0);
		rg(BROWNOUT_OFF, 32'h0);
		wr(WRITE_PROTECT_OFF, 32'h0);
		rg(WRITE_PROTECT_OFF, 32'h0);
		chk({31'h0, unlocked_o}, 32'h0);
		finish_test();
	end
endmodule
`default_nettype wire
